//--- inc/asp_pkg.sv
// constants for the second serial port with its receive fifo
//
// Contract
// - Transmit and receive paths run at the same time, independently.
// - A private baud generator: 16-bit timer plus selectable prescaler.
// - The receive fifo holds three bytes; a fourth byte is an overflow.
// - Six registers: baud control, reload high and low, format, control, data.
// - A write to the data location loads only the transmit holding register.
// - A read of the data location returns the oldest fifo byte, never tx data.
// - With interrupt enabled, tx done or rx available raises the request.
// - Flags stay set until software clears them; hardware never clears them.
// - Clearing rx available has no effect while the fifo still holds bytes.
// - Timer counts up from reload per prescaled tick; prescaler 1, 4, 12, 48.
// - With the baud generator disabled nothing is sent or received.
// - Frame: low start, 5-8 data bits lsb first, optional ninth bit, high stops.
// - Even, odd, mark, space parity; no extra bit with parity; long stop 6-8 bits.
package asp_pkg;
  // register offsets
  localparam logic [2:0] ADDR_CTRL = 3'h0; // serial_control_reg
  localparam logic [2:0] ADDR_FMT  = 3'h1; // serial_format_reg
  localparam logic [2:0] ADDR_BCON = 3'h2; // baud_gen_control
  localparam logic [2:0] ADDR_RLDH = 3'h3; // baud_reload_high
  localparam logic [2:0] ADDR_RLDL = 3'h4; // baud_reload_low
  localparam logic [2:0] ADDR_DATA = 3'h5; // serial_data_port
  // control register bits
  localparam int C_TXDONE = 0;
  localparam int C_RXAV   = 1;
  localparam int C_OVF    = 2;
  localparam int C_REN    = 3;
  localparam int C_BUSY   = 4;
  localparam int C_IEN    = 5;
  localparam int C_RXX    = 6;
  localparam int C_PERR   = 7;
  // format register fields
  localparam int F_LEN    = 0; // two bits, 0 = 5 bits .. 3 = 8 bits
  localparam int F_PE     = 2;
  localparam int F_PTYP   = 3; // two bits
  localparam int F_XBE    = 5;
  localparam int F_LSTOP  = 6;
  localparam int F_TXX    = 7;
  // baud control fields
  localparam int B_PS     = 0; // two bits
  localparam int B_EN     = 6;
  // parity types
  localparam logic [1:0] PAR_ODD   = 2'h0;
  localparam logic [1:0] PAR_EVEN  = 2'h1;
  localparam logic [1:0] PAR_MARK  = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  // prescale divisors by select code
  localparam logic [5:0] PS_DIV0 = 6'h0C;
  localparam logic [5:0] PS_DIV1 = 6'h04;
  localparam logic [5:0] PS_DIV2 = 6'h30;
  localparam logic [5:0] PS_DIV3 = 6'h01;
  // reset values
  localparam logic [7:0]  RST_FMT    = 8'h03;
  localparam logic [7:0]  RST_BCON   = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam int          RX_DEPTH   = 3;
  localparam logic [15:0] TMR_MAX    = 16'hFFFF;
  localparam logic [3:0]  MIN_LEN    = 4'h5;
endpackage

//--- rtl/asp_fifo.sv
// small receive fifo with valid/ready on both sides and a registered head
`timescale 1ns/1ps
module asp_fifo
  import asp_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = RX_DEPTH
) (
  input  wire logic         clk_i,       // core clock
  input  wire logic         rst_n_i,     // sync reset, low
  input  wire logic         in_valid_i,  // write request
  output logic              in_ready_o,  // room left
  input  wire logic [W-1:0] in_data_i,   // write data
  output logic              out_valid_o, // head present
  input  wire logic         out_ready_i, // pop
  output logic [W-1:0]      out_data_o   // registered head
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW-1:0] next_rp;
  logic [CW-1:0] cnt;
  logic          push;
  logic          pop;
  assign push        = in_valid_i && (cnt != FULL);
  assign pop         = out_ready_i && (cnt != '0);
  assign in_ready_o  = (cnt != FULL);
  assign out_valid_o = (cnt != '0);
  assign next_rp     = (rp == LAST) ? '0 : rp + 1'b1;
  // storage written per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (push && wp == PW'(i)) begin
        mem[i] <= in_data_i;
      end
    end
  end
  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == LAST) ? '0 : wp + 1'b1;
      if (pop) rp <= next_rp;
      cnt <= cnt + CW'(push) - CW'(pop);
    end
  end
  // head kept in a register so reads come from a flop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_data_o <= '0;
    end else if (push && (cnt == '0 || (pop && cnt == CW'(1)))) begin
      out_data_o <= in_data_i;
    end else if (pop) begin
      out_data_o <= mem[next_rp];
    end
  end
endmodule

//--- rtl/asp_baud.sv
// baud generator: prescaler and 16-bit reload timer, overflow gives a half-bit tick
`timescale 1ns/1ps
module asp_baud
  import asp_pkg::*;
(
  input  wire logic        clk_i,    // core clock
  input  wire logic        rst_n_i,  // sync reset, low
  input  wire logic        en_i,     // generator enable
  input  wire logic [1:0]  ps_sel_i, // prescale select
  input  wire logic [15:0] reload_i, // timer reload
  output logic             tick_o    // one pulse per overflow
);
  logic [5:0]  psc;
  logic [5:0]  div;
  logic [15:0] tmr;
  logic        ps_tick;
  always_comb begin
    case (ps_sel_i)
      2'h0:    div = PS_DIV0;
      2'h1:    div = PS_DIV1;
      2'h2:    div = PS_DIV2;
      default: div = PS_DIV3;
    endcase
  end
  assign ps_tick = en_i && (psc == div - 6'h01);
  // prescaler counter, held cleared while disabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_i) begin
      psc <= '0;
    end else begin
      psc <= ps_tick ? 6'h00 : psc + 6'h01;
    end
  end
  // timer counts up from reload and reloads on overflow
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tmr    <= RST_RELOAD;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      tmr    <= reload_i;
      tick_o <= 1'b0;
    end else begin
      tick_o <= ps_tick && (tmr == TMR_MAX);
      if (ps_tick) tmr <= (tmr == TMR_MAX) ? reload_i : tmr + 16'h0001;
    end
  end
endmodule

//--- rtl/asp_top.sv
// serial port top: register port, transmitter, receiver and receive fifo
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module asp_top
  import asp_pkg::*;
(
  input  wire logic       ref_clk_i, // core clock, 20 MHz
  input  wire logic       rst_n_i,   // sync reset, low
  input  wire logic [2:0] addr_i,    // register address
  input  wire logic [7:0] wdata_i,   // write data
  input  wire logic       wr_i,      // write strobe
  input  wire logic       rd_i,      // read strobe
  output logic      [7:0] rdata_o,   // read data, cycle after rd_i
  input  wire logic       rx_i,      // serial input pin
  output logic            tx_o,      // serial output pin
  output logic            irq_o      // interrupt request
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} asp_rx_t;

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [7:0]  fmt;
  logic [7:0]  bcon;
  logic [15:0] reload;
  logic        ren;
  logic        ien;
  logic        tx_done;
  logic        rx_avail;
  logic        ovf;
  logic        perr;
  logic        rx_x;
  logic [7:0]  thr;
  logic        thr_full;
  logic        tick;
  logic        wr_ctrl;
  logic        wr_data;
  logic        rd_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic [7:0]  fifo_dout;
  logic        rx_push;
  logic [7:0]  rx_sh;
  logic        tx_busy;
  logic        tx_end;
  logic        rx_end;
  logic [3:0]  dlen;
  logic        has_x;
  logic        two_stop;
  logic [7:0]  ctrl_rd;

  assign wr_ctrl  = wr_i && addr_i == ADDR_CTRL;
  assign wr_data  = wr_i && addr_i == ADDR_DATA;
  assign rd_data  = rd_i && addr_i == ADDR_DATA;
  assign dlen     = MIN_LEN + {2'h0, fmt[F_LEN+:2]};
  // the ninth bit is parity or extra, extra ignored while parity is on
  assign has_x    = fmt[F_PE] || fmt[F_XBE];
  // long stop only offered for 6 to 8 data bits
  assign two_stop = fmt[F_LSTOP] && (fmt[F_LEN+:2] != 2'h0);

  // parity over the active data bits
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
                                   input logic [1:0] typ);
    logic x;
    x = ^(d & (8'hFF >> (2'h3 - len)));
    case (typ)
      PAR_ODD:  par_bit = ~x;
      PAR_EVEN: par_bit = x;
      PAR_MARK: par_bit = 1'b1;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  // configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fmt    <= RST_FMT;
      bcon   <= RST_BCON;
      reload <= RST_RELOAD;
      ren    <= 1'b0;
      ien    <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == ADDR_FMT) begin
        fmt <= wdata_i;
      end else if (addr_i == ADDR_BCON) begin
        bcon <= wdata_i;
      end else if (addr_i == ADDR_RLDH) begin
        reload[15:8] <= wdata_i;
      end else if (addr_i == ADDR_RLDL) begin
        reload[7:0] <= wdata_i;
      end else if (addr_i == ADDR_CTRL) begin
        ren <= wdata_i[C_REN];
        ien <= wdata_i[C_IEN];
      end
    end
  end

  // status flags: writing 0 clears, hardware set wins over a same-cycle clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_done  <= 1'b0;
      rx_avail <= 1'b0;
      ovf      <= 1'b0;
      perr     <= 1'b0;
    end else begin
      if (tx_end) tx_done <= 1'b1;
      else if (wr_ctrl && !wdata_i[C_TXDONE]) tx_done <= 1'b0;
      if (rx_push && fifo_ready) rx_avail <= 1'b1;
      // clear refused while bytes wait in the fifo
      else if (wr_ctrl && !wdata_i[C_RXAV] && !fifo_valid) rx_avail <= 1'b0;
      if (rx_push && !fifo_ready) ovf <= 1'b1;
      else if (wr_ctrl && !wdata_i[C_OVF]) ovf <= 1'b0;
      if (rx_end && fmt[F_PE] &&
          rx_x != par_bit(rx_sh, fmt[F_LEN+:2], fmt[F_PTYP+:2])) perr <= 1'b1;
      else if (wr_ctrl && !wdata_i[C_PERR]) perr <= 1'b0;
    end
  end

  assign ctrl_rd = {perr, rx_x, ien, tx_busy, ren, ovf, rx_avail, tx_done};

  // read port: data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == ADDR_CTRL) begin
        rdata_o <= ctrl_rd;
      end else if (addr_i == ADDR_FMT) begin
        rdata_o <= fmt;
      end else if (addr_i == ADDR_BCON) begin
        rdata_o <= bcon;
      end else if (addr_i == ADDR_RLDH) begin
        rdata_o <= reload[15:8];
      end else if (addr_i == ADDR_RLDL) begin
        rdata_o <= reload[7:0];
      end else if (addr_i == ADDR_DATA) begin
        rdata_o <= fifo_dout;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // interrupt request from the two flags
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) irq_o <= 1'b0;
    else irq_o <= ien && (tx_done || rx_avail);
  end

  asp_baud u_baud (
    .clk_i    (ref_clk_i),
    .rst_n_i  (rst_n_i),
    .en_i     (bcon[B_EN]),
    .ps_sel_i (bcon[B_PS+:2]),
    .reload_i (reload),
    .tick_o   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: frame shifted lsb first, two half-bit ticks per bit
  logic [11:0] tx_fr;
  logic [11:0] next_fr;
  logic [3:0]  next_cnt;
  logic [3:0]  tx_left;
  logic        tx_ph;

  assign tx_busy = (tx_left != 4'h0);
  assign tx_end  = tick && tx_busy && tx_ph && tx_left == 4'h1;

  // build start, data, ninth bit and stop bits; unused tail stays high
  always_comb begin
    next_fr    = 12'hFFF;
    next_fr[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < dlen) next_fr[i+1] = thr[i];
    end
    if (has_x) begin
      next_fr[dlen+4'h1] = fmt[F_PE] ? par_bit(thr, fmt[F_LEN+:2], fmt[F_PTYP+:2])
                                     : fmt[F_TXX];
    end
    next_cnt = 4'h2 + dlen + 4'(has_x) + 4'(two_stop);
  end

  // holding register: loaded by writes only, emptied when a frame starts
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      thr      <= 8'h00;
      thr_full <= 1'b0;
    end else if (wr_data) begin
      thr      <= wdata_i;
      thr_full <= 1'b1;
    end else if (tick && !tx_busy) begin
      thr_full <= 1'b0;
    end
  end

  // shifter runs on its own, untouched by the receiver
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_fr   <= 12'hFFF;
      tx_left <= 4'h0;
      tx_ph   <= 1'b0;
      tx_o    <= 1'b1;
    end else if (tick) begin
      if (!tx_busy) begin
        if (thr_full) begin
          tx_fr   <= next_fr;
          tx_left <= next_cnt;
          tx_ph   <= 1'b0;
          tx_o    <= 1'b0;
        end
      end else begin
        tx_ph <= ~tx_ph;
        if (tx_ph) begin
          tx_left <= tx_left - 4'h1;
          tx_fr   <= {1'b1, tx_fr[11:1]};
          tx_o    <= (tx_left == 4'h1) ? 1'b1 : tx_fr[1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: pin synchronised, start checked at the next half-bit tick, then per bit
  logic    rx_s1;
  logic    rx_s2;
  logic    rx_s3;
  logic    rx_line;
  logic    rx_ph;
  logic [3:0] rx_cnt;
  asp_rx_t rx_st;

  // three stages; the line moves only when the last two agree
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      rx_s1 <= rx_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_line <= rx_s3;
    end
  end

  assign rx_end  = tick && rx_st == RX_STOP && rx_ph;
  // the start edge is only caught to half-bit resolution of the shared timer,
  // so sample points wander over roughly the first half of each bit
  assign rx_push = rx_end;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !ren) begin
      rx_st  <= RX_IDLE;
      rx_ph  <= 1'b0;
      rx_cnt <= 4'h0;
      rx_sh  <= 8'h00;
      rx_x   <= 1'b0;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          if (!rx_line && bcon[B_EN]) rx_st <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            rx_st  <= rx_line ? RX_IDLE : RX_BITS;
            rx_ph  <= 1'b0;
            rx_cnt <= 4'h0;
            rx_sh  <= 8'h00;
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_ph <= ~rx_ph;
            if (rx_ph) begin
              if (rx_cnt < dlen) rx_sh[rx_cnt[2:0]] <= rx_line;
              else rx_x <= rx_line;
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt + 4'h1 == dlen + 4'(has_x)) rx_st <= RX_STOP;
            end
          end
        end
        default: begin
          if (tick) begin
            rx_ph <= ~rx_ph;
            if (rx_ph) rx_st <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // a full fifo refuses the push, the new byte is lost and stored ones kept
  asp_fifo #(
    .W     (8),
    .DEPTH (RX_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rx_sh),
    .out_valid_o (fifo_valid),
    .out_ready_i (rd_data),
    .out_data_o  (fifo_dout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  tx_idle_high_a: assert property (!tx_busy |=> tx_o || tx_busy)
    else $error("line not high while idle");
  tx_start_low_a: assert property ($rose(tx_busy) |-> !tx_o ##1 !tx_o)
    else $error("start bit not low");
  baud_off_a: assert property (!bcon[B_EN] [*2] |-> !tick)
    else $error("baud tick while disabled");
  rd_fifo_a: assert property (rd_data |=> rdata_o == $past(fifo_dout))
    else $error("data read not fifo head");
  wr_thr_a: assert property (wr_data |=> thr == $past(wdata_i) && thr_full)
    else $error("write missed holding register");
  rx_hold_a: assert property (rx_avail && fifo_valid |=> rx_avail)
    else $error("rx flag cleared with bytes left");
  ovf_set_a: assert property (rx_push && !fifo_ready |=> ovf && fifo_valid)
    else $error("overflow not flagged");
  irq_req_a: assert property (ien && (tx_done || rx_avail) |=> irq_o)
    else $error("interrupt not raised");
  tx_done_a: assert property ($fell(tx_busy) |-> tx_done && tx_o)
    else $error("tx done missing after stop");
  flag_keep_a: assert property (tx_done && !wr_ctrl |=> tx_done)
    else $error("tx done dropped by hardware");

  ovf_seen_c: cover property (rx_push && !fifo_ready);
  tx_frame_c: cover property ($fell(tx_busy));
  rx_byte_c: cover property (rx_push && fifo_ready);
  rd_pop_c: cover property (rd_data && fifo_valid);
endmodule

//--- dv/asp_remote_node.sv
// remote serial node model: frames bytes onto the port input, decodes its output
`timescale 1ns/1ps
module asp_remote_node (
  input  wire logic clk_i,  // core clock of the bench
  input  wire logic line_i, // serial output of the port
  output logic      line_o  // serial input of the port
);
  int         bit_clks = 32; // bit time in clocks
  int         nbits    = 8;  // data bits expected
  bit         pe       = 0;  // ninth bit expected
  logic [9:0] got_q[$];      // {stop, ninth, data}

  initial line_o = 1'b1; // pulled-up line idles high

  // one bit time on the line, entered just after a rising edge
  task automatic drive(input logic v);
    line_o <= v;
    repeat (bit_clks) @(posedge clk_i);
  endtask

  // start low, data lsb first, optional ninth bit, high stops
  task automatic send(input logic [7:0] d, input int n, input bit xb, input logic xv,
                      input int stops);
    int i;
    @(posedge clk_i);
    drive(1'b0);
    for (i = 0; i < n; i++) drive(d[i]);
    if (xb) drive(xv);
    repeat (stops) drive(1'b1);
  endtask

  // decoder samples mid-bit on the falling edge, clear of the port's own updates
  initial begin
    logic [9:0] f;
    int         i;
    forever begin
      @(negedge clk_i);
      if (line_i === 1'b0) begin
        f = '0;
        repeat (bit_clks / 2) @(negedge clk_i);
        for (i = 0; i < nbits; i++) begin
          repeat (bit_clks) @(negedge clk_i);
          f[i] = line_i;
        end
        if (pe) begin
          repeat (bit_clks) @(negedge clk_i);
          f[8] = line_i;
        end
        repeat (bit_clks) @(negedge clk_i);
        f[9] = line_i;
        got_q.push_back(f);
      end
    end
  end
endmodule

//--- dv/tb_async_serial_port_rx_fifo.sv
// self-checking bench of the serial port with receive fifo
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_async_serial_port_rx_fifo;
  import asp_pkg::*;
  logic       ref_clk_i, rst_n_i, wr_i, rd_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, c, d, rb[3];
  logic       rx_i, tx_o, irq_o;
  logic [9:0] g;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         seed = 56533;
  int         cyc = 0;
  int         w, i, k, n;
  logic [1:0] pt, ln;
  logic       pe, xbe, ls, txx;
  logic [7:0] rl[4] = '{8'hFC, 8'hF8, 8'hFF, 8'hF0};
  logic [5:0] dv[4] = '{PS_DIV0, PS_DIV1, PS_DIV2, PS_DIV3};

  asp_top uut (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_i,
               .tx_o, .irq_o);
  asp_remote_node node (.clk_i(ref_clk_i), .line_i(tx_o), .line_o(rx_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: a whole run needs far fewer cycles than this
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // register bus: one-cycle strobes, a spare cycle between accesses
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  // control word: flag bits written 1 are left alone, 0 clears them
  function automatic logic [7:0] cw(input logic ren, ien, input logic [3:0] keep);
    return {keep[3], 1'b0, ien, 1'b0, ren, keep[2:0]};
  endfunction
  function automatic logic par(input logic [7:0] m, input logic [1:0] t);
    case (t)
      PAR_ODD:  return ~^m;
      PAR_EVEN: return ^m;
      PAR_MARK: return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction

  task automatic wait_flag(input int b);
    int m;
    c = '0;
    for (m = 0; m < 3000 && c[b] !== 1'b1; m++) rd(ADDR_CTRL, c);
  endtask
  task automatic get_frame();
    int m;
    for (m = 0; m < 6000 && node.got_q.size() == 0; m++) @(posedge ref_clk_i);
    g = (node.got_q.size() != 0) ? node.got_q.pop_front() : 10'h3FF;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = '0; wdata_i = '0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped places read zero and ignore writes
    wr(3'h6, 8'h5A);
    for (k = 0; k < 8; k++) begin
      rd(k[2:0], c);
      case (k)
        1: `CHK(c, RST_FMT)
        2: `CHK(c, RST_BCON)
        3: `CHK(c, RST_RELOAD[15:8])
        4: `CHK(c, RST_RELOAD[7:0])
        default: `CHK(c, 8'h00)
      endcase
    end
    $display("test reset_map done");
    // generator off: a loaded byte stays put, an arriving frame is ignored
    wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'h0));
    wr(ADDR_DATA, 8'h81);
    node.send(8'h11, 8, 0, 1'b0, 1);
    @(negedge ref_clk_i);
    `CHK(tx_o, 1'b1)
    rd(ADDR_CTRL, c);
    `CHK(c[1:0], 2'b00)
    $display("test baud_off done");
    // every prescale code, bit time measured on the start bit
    for (i = 0; i < 4; i++) begin
      wr(ADDR_RLDH, 8'hFF);
      wr(ADDR_RLDL, rl[i]);
      wr(ADDR_BCON, 8'h40 | 8'(i));
      node.bit_clks = 2 * (256 - int'(rl[i])) * int'(dv[i]);
      if (i > 0) wr(ADDR_DATA, 8'hA5);
      w = 0;
      for (n = 0; n < 4000 && tx_o !== 1'b0; n++) @(negedge ref_clk_i);
      while (tx_o === 1'b0 && w < 4000) begin
        @(negedge ref_clk_i);
        w++;
      end
      `CHK(w, node.bit_clks)
      get_frame();
      `CHK(g, {2'b10, (i == 0) ? 8'h81 : 8'hA5})
      rd(ADDR_CTRL, c);
      `CHK(c[C_TXDONE], 1'b0)
      wait_flag(C_TXDONE);
      `CHK(c[C_TXDONE], 1'b1)
      wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'hE));
    end
    rd(ADDR_RLDL, c);
    `CHK(c, 8'hF0)
    $display("test prescale done");
    // random formats: length, parity kind, extra bit, long stop
    for (k = 0; k < 6; k++) begin
      {txx, ls, xbe, pt, pe, ln} = 8'($random(seed));
      d = 8'($random(seed));
      // corner cases: every parity kind once, then the extra bit alone
      if (k < 4) {pe, pt} = {1'b1, k[1:0]};
      if (k == 5) {pe, xbe} = 2'b01;
      node.nbits = int'(ln) + 5;
      node.pe = pe | xbe;
      wr(ADDR_FMT, {txx, ls, xbe, pt, pe, ln});
      wr(ADDR_DATA, d);
      get_frame();
      `CHK(g[7:0], d & ((8'h01 << node.nbits) - 8'h01))
      if (pe | xbe) `CHK(g[8], pe ? par(g[7:0], pt) : txx)
      `CHK(g[9], 1'b1)
      wait_flag(C_TXDONE);
      wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'hE));
    end
    $display("test formats done");
    // fill the fifo, overflow while sending, drain oldest first
    wr(ADDR_FMT, RST_FMT);
    node.nbits = 8;
    node.pe = 0;
    wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'h0));
    for (k = 0; k < 3; k++) begin
      rb[k] = 8'($random(seed));
      node.send(rb[k], 8, 0, 1'b0, 1);
    end
    repeat (64) @(posedge ref_clk_i);
    wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'hD));
    rd(ADDR_CTRL, c);
    `CHK(c[C_RXAV], 1'b1)
    fork
      node.send(8'h99, 8, 0, 1'b0, 1);
      wr(ADDR_DATA, 8'h3C);
    join
    repeat (64) @(posedge ref_clk_i);
    rd(ADDR_CTRL, c);
    `CHK(c[C_OVF], 1'b1)
    get_frame();
    `CHK(g[7:0], 8'h3C)
    for (k = 0; k < 3; k++) begin
      rd(ADDR_DATA, d);
      `CHK(d, rb[k])
    end
    rd(ADDR_CTRL, c);
    `CHK(c[C_RXAV], 1'b1)
    wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'h0));
    rd(ADDR_CTRL, c);
    `CHK(c[2:0], 3'b000)
    $display("test rx_fifo done");
    // interrupt follows enable and both flags until software clears them
    // irq is looked at on the falling edge, well clear of its launch edge
    wr(ADDR_CTRL, cw(1'b1, 1'b1, 4'h0));
    repeat (3) @(negedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    wr(ADDR_DATA, 8'h5A);
    get_frame();
    wait_flag(C_TXDONE);
    repeat (3) @(negedge ref_clk_i);
    `CHK(irq_o, 1'b1)
    wr(ADDR_CTRL, cw(1'b1, 1'b0, 4'hF));
    repeat (3) @(negedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    wr(ADDR_CTRL, cw(1'b1, 1'b1, 4'hE));
    repeat (3) @(negedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    node.send(8'h42, 8, 0, 1'b0, 1);
    repeat (64) @(negedge ref_clk_i);
    `CHK(irq_o, 1'b1)
    rd(ADDR_DATA, d);
    `CHK(d, 8'h42)
    $display("test interrupt done");
    finish_test();
  end
endmodule
